// ---- rtl/rcq_pkg.sv ----
// constants and carrier types for the random-address command queue
package rcq_pkg;

  // ---------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 48;        // processor block address width
  localparam int ADDR_LSB = 3;       // lowest stored address bit
  localparam int BLK_W = ADDR_W - ADDR_LSB;   // 45 stored bits
  localparam logic [ADDR_LSB-1:0] ADDR_PAD = 3'h0;   // restored low bits

  // ---------------------------------------------------------------
  // queue sizing and counters
  // ---------------------------------------------------------------
  localparam int QDEPTH = 1024;      // entries per address queue
  localparam int PTR_W = 10;         // queue pointer width
  localparam int CNT_W = 11;         // fill counter width, 0..1024
  localparam logic [CNT_W-1:0] FREE_RST = 11'h400;  // empty queue room
  localparam int CC_W = 32;          // completed command counter width
  localparam int OC_W = 6;           // core outstanding count width
  localparam logic [CC_W-1:0] CC_RST = 32'h0;

  // one buffered header address slot
  typedef struct packed {
    logic vld;
    logic [BLK_W-1:0] blk;
  } rcq_slot_s;

endpackage : rcq_pkg

// ---- rtl/rcq_fifo.sv ----
// first-word-fall-through address queue with fill counter
module rcq_fifo
  import rcq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // write side
  input wire logic push,
  input wire logic [BLK_W-1:0] push_data,
  output logic full,
  // read side, data valid while not empty
  input wire logic pop,
  output logic [BLK_W-1:0] pop_data,
  output logic empty,
  // occupancy
  output logic [CNT_W-1:0] count
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  logic [BLK_W-1:0] mem_q [QDEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  // guarded strobes: overflow and underflow are ignored
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign full = (cnt_q == CNT_W'(QDEPTH));
  assign empty = (cnt_q == '0);
  assign count = cnt_q;
  // fall-through: head word is visible without a read
  assign pop_data = mem_q[rd_ptr_q];

  // array write carries no reset so it maps to memory
  always_ff @(posedge mclk)
  begin
    if (do_push)
      mem_q[wr_ptr_q] <= push_data;
  end

  // pointers and counter
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_q <= wr_ptr_q + PTR_W'(1);
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + PTR_W'(1);
      cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

endmodule // rcq_fifo

// ---- rtl/rcq_addr_queue.sv ----
// random-address command queue: twin address queues and issue logic
//
// Behaviour
// - store only address bits 47 to 3
// - free space from header queue count and skid slots only
// - each queue holds 1024 entries
// - command and data sides pop independently
// - multi-command request here, single-mode from processor
// - pop in multi-command mode when non-empty, core ready and no request registered
// - request strobe follows fall-through queue pop
// - sticky flag when command queue empties during a multi-command run
// - completed equals issued minus outstanding
module rcq_addr_queue
  import rcq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // processor address writes and status
  input wire logic cpu_addr_wr,
  input wire logic [ADDR_W-1:0] cpu_addr,
  output logic [CNT_W-1:0] address_free_space_count,
  output logic slow_source_flag,
  output logic [CC_W-1:0] completed_command_count,
  // run control
  input wire logic run_active,
  input wire logic single_mode,
  input wire logic cpu_cmd_request,
  // core command interface
  input wire logic core_command_ready,
  input wire logic [OC_W-1:0] outstanding_command_count,
  output logic core_command_request,
  output logic [ADDR_W-1:0] core_command_address,
  // data path header interface
  input wire logic header_queue_pop,
  output logic header_queue_empty,
  output logic [ADDR_W-1:0] header_address
);

  // ---------------------------------------------------------------
  // queue instances
  // ---------------------------------------------------------------
  logic [BLK_W-1:0] wr_blk;
  logic cmd_full;
  logic hdr_full;
  logic push_ok;
  logic command_queue_pop;
  logic command_queue_empty;
  logic [BLK_W-1:0] cmd_dout;
  logic [CNT_W-1:0] cmd_cnt;
  logic hdr_fifo_empty;
  logic [BLK_W-1:0] hdr_dout;
  logic [CNT_W-1:0] hdr_cnt;
  logic hdr_fill;

  // low three bits are always zero on aligned blocks, so drop them
  assign wr_blk = cpu_addr[ADDR_W-1:ADDR_LSB];
  // a write lands in both queues or in neither, keeping them in step
  assign push_ok = cpu_addr_wr & ~cmd_full & ~hdr_full;

  rcq_fifo u_command_address_queue (
    .mclk(mclk),
    .rst_n(rst_n),
    .push(push_ok),
    .push_data(wr_blk),
    .full(cmd_full),
    .pop(command_queue_pop),
    .pop_data(cmd_dout),
    .empty(command_queue_empty),
    .count(cmd_cnt)
  );

  rcq_fifo u_header_address_queue (
    .mclk(mclk),
    .rst_n(rst_n),
    .push(push_ok),
    .push_data(wr_blk),
    .full(hdr_full),
    .pop(hdr_fill),
    .pop_data(hdr_dout),
    .empty(hdr_fifo_empty),
    .count(hdr_cnt)
  );

  // ---------------------------------------------------------------
  // command issue
  // ---------------------------------------------------------------
  logic req_q;
  logic [BLK_W-1:0] req_blk_q;
  logic req_d;

  // one pop per two cycles: ready is sampled one cycle behind request
  assign command_queue_pop = ~single_mode & ~command_queue_empty
                           & core_command_ready & ~req_q;
  // request source depends on the command mode
  assign req_d = single_mode ? cpu_cmd_request : command_queue_pop;

  // request registered straight off the pop, with the head word
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      req_q <= 1'b0;
      req_blk_q <= '0;
    end
    else
    begin
      req_q <= req_d;
      if (command_queue_pop)
        req_blk_q <= cmd_dout;
    end
  end

  assign core_command_request = req_q;
  assign core_command_address = {req_blk_q, ADDR_PAD};

  // ---------------------------------------------------------------
  // header skid buffer (two slots, head always in slot 0)
  // ---------------------------------------------------------------
  rcq_slot_s s0_q, s1_q, s0_d, s1_d;
  logic hq_empty_q;
  logic dp_pop;

  // refill only while slot 1 is free; a stalled data path backs up
  assign hdr_fill = ~s1_q.vld & ~hdr_fifo_empty;
  assign dp_pop = header_queue_pop & s0_q.vld;

  // next slot contents
  always_comb
  begin
    s0_d = s0_q;
    s1_d = s1_q;
    if (dp_pop)
    begin
      s1_d = '0;
      if (s1_q.vld)
        s0_d = s1_q;
      else if (hdr_fill)
        s0_d = '{vld: 1'b1, blk: hdr_dout};
      else
        s0_d = '0;
    end
    else if (hdr_fill)
    begin
      if (s0_q.vld)
        s1_d = '{vld: 1'b1, blk: hdr_dout};
      else
        s0_d = '{vld: 1'b1, blk: hdr_dout};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s0_q <= '0;
      s1_q <= '0;
      hq_empty_q <= 1'b1;
    end
    else
    begin
      s0_q <= s0_d;
      s1_q <= s1_d;
      hq_empty_q <= ~s0_d.vld;
    end
  end

  assign header_queue_empty = hq_empty_q;
  assign header_address = {s0_q.blk, ADDR_PAD};

  // ---------------------------------------------------------------
  // status: free space, slow source, completions
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] free_q;
  logic run_q;
  logic run_start;
  logic slow_q;
  logic slow_set;
  logic [CC_W-1:0] issued_q;
  logic [CC_W-1:0] comp_q;

  assign run_start = run_active & ~run_q;
  // an empty command queue mid-run means the processor fell behind
  assign slow_set = run_active & ~single_mode & command_queue_empty;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      free_q <= FREE_RST;
      run_q <= 1'b0;
      slow_q <= 1'b0;
      issued_q <= CC_RST;
      comp_q <= CC_RST;
    end
    else
    begin
      // header path drains last, so its room is the smaller of the two;
      // the prefetched slots count as used, else a full command queue
      // could still report room and silently drop a write
      free_q <= CNT_W'(QDEPTH) - hdr_cnt - CNT_W'(s0_q.vld)
              - CNT_W'(s1_q.vld);
      run_q <= run_active;
      // set beats the clear at run start
      slow_q <= slow_set | (slow_q & ~run_start);
      if (run_start)
        issued_q <= CC_W'(command_queue_pop);
      else if (command_queue_pop)
        issued_q <= issued_q + CC_W'(1);
      comp_q <= issued_q - CC_W'(outstanding_command_count);
    end
  end

  assign address_free_space_count = free_q;
  assign slow_source_flag = slow_q;
  assign completed_command_count = comp_q;

  // ---------------------------------------------------------------
  // assertions and covers
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  low_bits_zero_a: assert property (
    core_command_address[2:0] == 3'h0 && header_address[2:0] == 3'h0)
    else $error("address low bits not zero");

  twin_push_a: assert property (
    push_ok && !command_queue_pop |=> cmd_cnt == $past(cmd_cnt) + 11'h1)
    else $error("command queue missed a twin push");

  free_space_a: assert property (
    ##1 address_free_space_count == 11'h400 - $past(hdr_cnt)
    - CNT_W'($past(s0_q.vld)) - CNT_W'($past(s1_q.vld)))
    else $error("free space not from header count");

  queue_depth_a: assert property (
    cmd_cnt <= 11'h400 && hdr_cnt <= 11'h400 &&
    (cmd_full == (cmd_cnt == 11'h400)))
    else $error("queue depth exceeded");

  pop_guard_a: assert property (
    core_command_request && !$past(single_mode) |->
    $past(core_command_ready) && !$past(command_queue_empty))
    else $error("request without data or ready");

  req_follows_pop_a: assert property (
    command_queue_pop |=> core_command_request &&
    core_command_address[47:3] == $past(cmd_dout))
    else $error("request does not follow pop");

  single_source_a: assert property (
    single_mode |=> core_command_request == $past(cpu_cmd_request))
    else $error("single-mode request not from processor");

  slow_sticky_a: assert property (
    slow_set |=> slow_source_flag ##1 (slow_source_flag || $past(run_start)))
    else $error("slow flag not set or lost");

  comp_count_a: assert property (
    ##1 completed_command_count ==
    $past(issued_q) - CC_W'($past(outstanding_command_count)))
    else $error("completed count mismatch");

  c_issue_c: cover property (command_queue_pop ##2 command_queue_pop);
  c_full_c: cover property (cmd_full && cpu_addr_wr);
  c_stall_c: cover property ((s1_q.vld && !header_queue_pop) [*3]);
  c_slow_c: cover property ($rose(slow_source_flag));

endmodule // rcq_addr_queue

// ---- tb/rcq_core_model.sv ----
// behavioural model of the storage core command side
module rcq_core_model
  import rcq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // command handshake
  input wire logic core_command_request,
  input wire logic hold,
  output logic core_command_ready,
  output logic [OC_W-1:0] outstanding_command_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // completion pacing
  // ---------------------------------------------------------------
  logic [1:0] tick_q;
  logic done;
  // one command retires every four cycles, slower than issue on purpose
  assign done = (tick_q == 2'h3) && (outstanding_command_count != 6'h0);
  // the core keeps at most 32 commands in flight
  assign core_command_ready = !hold && (outstanding_command_count < 6'h20);

  // outstanding count follows requests in and completions out
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tick_q <= 2'h0;
      outstanding_command_count <= 6'h0;
    end
    else
    begin
      tick_q <= tick_q + 2'h1;
      outstanding_command_count <= outstanding_command_count
        + {5'h0, core_command_request} - {5'h0, done};
    end
  end
endmodule // rcq_core_model

// ---- tb/test_rcq_addr_queue.sv ----
// self-checking bench for the random-address command queue
module test_rcq_addr_queue
  import rcq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_n = 1'b0, cpu_addr_wr = 1'b0, run_active = 1'b0;
  logic single_mode = 1'b0, cpu_cmd_request = 1'b0, header_queue_pop = 1'b0;
  logic hold = 1'b1, core_command_ready, core_command_request;
  logic slow_source_flag, header_queue_empty;
  logic [ADDR_W-1:0] cpu_addr = 48'h0, core_command_address, header_address;
  logic [CNT_W-1:0] address_free_space_count;
  logic [CC_W-1:0] completed_command_count;
  logic [OC_W-1:0] outstanding_command_count;
  logic [ADDR_W-1:0] got[$];
  int mismatches = 0, num_checks = 0;

  always #50 mclk = ~mclk;

  rcq_addr_queue rcq_addr_queue_i (.mclk(mclk), .rst_n(rst_n),
    .cpu_addr_wr(cpu_addr_wr), .cpu_addr(cpu_addr),
    .address_free_space_count(address_free_space_count),
    .slow_source_flag(slow_source_flag),
    .completed_command_count(completed_command_count),
    .run_active(run_active), .single_mode(single_mode),
    .cpu_cmd_request(cpu_cmd_request),
    .core_command_ready(core_command_ready),
    .outstanding_command_count(outstanding_command_count),
    .core_command_request(core_command_request),
    .core_command_address(core_command_address),
    .header_queue_pop(header_queue_pop),
    .header_queue_empty(header_queue_empty),
    .header_address(header_address));

  rcq_core_model rcq_core_model_i (.mclk(mclk), .rst_n(rst_n),
    .core_command_request(core_command_request), .hold(hold),
    .core_command_ready(core_command_ready),
    .outstanding_command_count(outstanding_command_count));

  // record every multi-mode request with the address it carries
  always @(posedge mclk)
    if (core_command_request === 1'b1 && single_mode === 1'b0)
      got.push_back(core_command_address);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // addresses keep bits 2:0 at zero, the processor's duty
  function automatic logic [ADDR_W-1:0] adr(int i);
    return 48'hf0e1_d2c3_b4a8 + 48'h0000_1010_1008 * i;
  endfunction

  task automatic check(logic [ADDR_W-1:0] seen, logic [ADDR_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one write, only when the queue reports room
  task automatic wr(logic [ADDR_W-1:0] a);
    @(negedge mclk);
    if (address_free_space_count != 11'h0)
    begin
      cpu_addr_wr = 1'b1;
      cpu_addr = a;
    end
    @(negedge mclk);
    cpu_addr_wr = 1'b0;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_fill;
    for (int i = 0; i < 5; i++)
      wr(adr(i));
    repeat (4) @(negedge mclk);
    check(address_free_space_count, 48'd1019);
    check(header_queue_empty, 48'h0);
    check(header_address, adr(0));
  endtask

  // commands drain while headers stay queued
  task automatic t_issue;
    @(negedge mclk);
    hold = 1'b0;
    run_active = 1'b1;
    repeat (3) @(negedge mclk);
    check(slow_source_flag, 48'h0);
    repeat (20) @(negedge mclk);
    check(got.size(), 48'd5);
    for (int i = 0; i < 5 && i < got.size(); i++)
      check(got[i], adr(i));
    check(slow_source_flag, 48'h1);
    check(address_free_space_count, 48'd1019);
    repeat (30) @(negedge mclk);
    check(completed_command_count, 48'd5);
  endtask

  task automatic t_headers;
    for (int i = 0; i < 5; i++)
    begin
      check(header_address, adr(i));
      header_queue_pop = 1'b1;
      @(negedge mclk);
      header_queue_pop = 1'b0;
      @(negedge mclk);
    end
    header_queue_pop = 1'b1;
    @(negedge mclk);
    header_queue_pop = 1'b0;
    repeat (3) @(negedge mclk);
    check(header_queue_empty, 48'h1);
    check(address_free_space_count, 48'd1024);
  endtask

  task automatic t_single;
    run_active = 1'b0;
    single_mode = 1'b1;
    @(negedge mclk);
    cpu_cmd_request = 1'b1;
    @(negedge mclk);
    cpu_cmd_request = 1'b0;
    check(core_command_request, 48'h1);
    @(negedge mclk);
    check(core_command_request, 48'h0);
  endtask

  // fill to the brim in single mode, where the command side never pops
  task automatic t_full;
    for (int i = 0; i < 1024; i++)
      wr(adr(i));
    repeat (3) @(negedge mclk);
    check(address_free_space_count, 48'h0);
    check(header_address, adr(0));
    // a write into a full command queue must land in neither queue
    cpu_addr_wr = 1'b1;
    cpu_addr = adr(2000);
    @(negedge mclk);
    cpu_addr_wr = 1'b0;
    repeat (3) @(negedge mclk);
    check(address_free_space_count, 48'h0);
  endtask

  // watchdog: the sequence needs under three thousand cycles
  initial
  begin
    #2000000;
    mismatches++;
    results();
  end

  initial
  begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    check(header_queue_empty, 48'h1);
    check(address_free_space_count, 48'd1024);
    t_fill();
    t_issue();
    t_headers();
    t_single();
    t_full();
    results();
  end
endmodule // test_rcq_addr_queue
